/* logic/chan_mux.sv */
// Channel source selector for one shared output
`timescale 1ns/1ps
module chan_mux
	import clk_cfg_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	// Clocking
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Selection and sources
	input wire logic [2:0] sel,
	input wire logic [CHANNELS-1:0] src,
	output logic out,
	output logic reserved_sel
);
	// Refused while elaborating, so a wrong width never reaches simulation
	if (CHANNELS != 4) begin : g_bad_channels
		$error("chan_mux serves four channels only");
	end
	wire sel_ok = (sel <= SEL_CH_LIMIT);
	// Reserved codes park the output low rather than pick a random channel
	wire next_out = sel_ok ? src[sel[1:0]] : 1'b0;
	assign reserved_sel = !sel_ok;
	always_ff @(posedge clk) begin
		if (rst) out <= 1'b0;
		else if (ce) out <= next_out;
	end
endmodule

/* logic/clk_cfg_pkg.sv */
// Package: register map, field layout, reset values and carrier types of the clock configuration block
package clk_cfg_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_SRC_SEL = 8'h8a;
	localparam logic [7:0] OFF_E1_CORR_LO = 8'h90;
	localparam logic [7:0] OFF_E1_CORR_HI = 8'h91;
	localparam logic [7:0] OFF_T1_CORR_LO = 8'h92;
	localparam logic [7:0] OFF_T1_CORR_HI = 8'h93;
	localparam logic [7:0] OFF_PLL_IN_DIV = 8'h96;
	localparam logic [7:0] OFF_PLL_FB_DIV = 8'h97;
	localparam logic [7:0] OFF_E1_PHASE = 8'h98;
	localparam logic [7:0] OFF_T1_PHASE = 8'h99;
	localparam logic [7:0] RST_SRC_SEL = 8'h00;
	localparam logic [7:0] RST_E1_CORR_LO = 8'h00;
	localparam logic [7:0] RST_E1_CORR_HI = 8'h10;
	localparam logic [7:0] RST_T1_CORR_LO = 8'h00;
	localparam logic [7:0] RST_T1_CORR_HI = 8'h00;
	localparam logic [7:0] RST_PLL_IN_DIV = 8'h00;
	localparam logic [7:0] RST_PLL_FB_DIV = 8'h00;
	localparam logic [7:0] RST_E1_PHASE = 8'h00;
	localparam logic [7:0] RST_T1_PHASE = 8'h00;
	localparam int FSS_LSB = 4;
	localparam int R1S_LSB = 0;
	localparam int FLEX_BIT = 4;
	localparam int SIXTHS_LSB = 4;
	localparam int INT_LSB = 0;
	localparam int LEGACY_LSB = 5;
	localparam int MCLK_LOW_BIT = 7;
	localparam logic [7:0] SRC_SEL_MASK = 8'h77;
	localparam logic [7:0] IN_DIV_MASK = 8'h9f;
	localparam logic [7:0] FB_DIV_MASK = 8'h3f;
	localparam logic [7:0] CORR_HI_MASK = 8'h0f;
	localparam logic [7:0] T1_HI_MASK = 8'hef;
	localparam logic [7:0] PHASE_MASK = 8'h7f;
	localparam logic [7:0] PHASE_FIXED = 8'h80;
	localparam logic [4:0] DEF_IN_DIV = 5'h00;
	localparam logic [5:0] DEF_FB_DIV = 6'h2f;
	localparam logic [11:0] DEF_E1_CORR = 12'h800;
	localparam logic [11:0] DEF_T1_CORR = 12'hbfb;
	localparam logic [2:0] DEF_SIXTHS = 3'h5;
	localparam logic [3:0] DEF_INT = 4'hb;
	localparam logic [2:0] SEL_CH_LIMIT = 3'h3;
	localparam logic [3:0] PLL_RST_CYCLES = 4'h8;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [4:0] in_div;
		logic [5:0] fb_div;
		logic [11:0] e1_corr;
		logic [11:0] t1_corr;
		logic [2:0] e1_sixths;
		logic [3:0] e1_int;
		logic [2:0] t1_sixths;
		logic [3:0] t1_int;
	} pll_cfg_t;
endpackage

/* logic/master_clock_pll_config.sv */
// Global clock configuration: shared output source select and master PLL settings
//
// How it works
// - frame sync source field bits 6:4, 1xx reserved
// - recv clock one source bits 2:0
// - E1 correction 12-bit, low byte plus nibble
// - T1 correction 12-bit, low byte plus nibble
// - flexible bit selects register divider values
// - divider write resets PLL if async and flexible
// - PLL output is input times 4(N+1)/(M+1)
// - input divider bits 4:0, values 1..31
// - feedback divider values 1..63
// - E1 phase register bit7 one, sixths, integer
// - T1 phase register same layout as E1
// - legacy fields stored but have no effect
`timescale 1ns/1ps
module master_clock_pll_config
	import clk_cfg_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter int PLL_RST_LEN = int'(PLL_RST_CYCLES)
) (
	// Clocking
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_hit,
	// Host interface mode straps
	input wire logic [1:0] host_interface_mode,
	// Per-channel sources
	input wire logic [CHANNELS-1:0] chan_frame_sync,
	input wire logic [CHANNELS-1:0] chan_recv_clock,
	// Shared outputs
	output logic frame_sync_output,
	output logic shared_recv_clock_one,
	output logic frame_sync_sel_reserved,
	output logic recv_clock_sel_reserved,
	// PLL configuration
	output pll_cfg_t pll_cfg,
	output logic flexible_clock_enable,
	output logic rx_decoder_mode_bit,
	output logic rx_decoder_direction_bit,
	output logic rx_decoder_select_bit,
	output logic divider_out_of_range,
	output logic pll_reset
);
	if (CHANNELS != 4) begin : g_bad_channels
		$error("four channels are required");
	end
	if (PLL_RST_LEN < 1 || PLL_RST_LEN > 15) begin : g_bad_rst_len
		$error("PLL_RST_LEN out of range");
	end

	reg_req_t req;
	assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

	logic [7:0] src_sel;
	logic [7:0] e1_lo;
	logic [7:0] e1_hi;
	logic [7:0] t1_lo;
	logic [7:0] t1_hi;
	logic [7:0] in_div;
	logic [7:0] fb_div;
	logic [7:0] e1_phase;
	logic [7:0] t1_phase;

	// Address decode
	wire hit_src = (req.addr == OFF_SRC_SEL);
	wire hit_e1_lo = (req.addr == OFF_E1_CORR_LO);
	wire hit_e1_hi = (req.addr == OFF_E1_CORR_HI);
	wire hit_t1_lo = (req.addr == OFF_T1_CORR_LO);
	wire hit_t1_hi = (req.addr == OFF_T1_CORR_HI);
	wire hit_in = (req.addr == OFF_PLL_IN_DIV);
	wire hit_fb = (req.addr == OFF_PLL_FB_DIV);
	wire hit_e1_ph = (req.addr == OFF_E1_PHASE);
	wire hit_t1_ph = (req.addr == OFF_T1_PHASE);
	wire any_hit = hit_src | hit_e1_lo | hit_e1_hi | hit_t1_lo | hit_t1_hi
		| hit_in | hit_fb | hit_e1_ph | hit_t1_ph;
	wire wr_en = ce & req.wr;

	always_ff @(posedge clk) begin
		if (rst) begin
			src_sel <= RST_SRC_SEL;
			e1_lo <= RST_E1_CORR_LO;
			e1_hi <= RST_E1_CORR_HI;
			t1_lo <= RST_T1_CORR_LO;
			t1_hi <= RST_T1_CORR_HI;
			in_div <= RST_PLL_IN_DIV;
			fb_div <= RST_PLL_FB_DIV;
			e1_phase <= RST_E1_PHASE;
			t1_phase <= RST_T1_PHASE;
		end else if (wr_en) begin
			if (hit_src) src_sel <= req.wdata & SRC_SEL_MASK;
			if (hit_e1_lo) e1_lo <= req.wdata;
			if (hit_e1_hi) e1_hi <= req.wdata;
			if (hit_t1_lo) t1_lo <= req.wdata;
			if (hit_t1_hi) t1_hi <= req.wdata & T1_HI_MASK;
			if (hit_in) in_div <= req.wdata & IN_DIV_MASK;
			if (hit_fb) fb_div <= req.wdata & FB_DIV_MASK;
			if (hit_e1_ph) e1_phase <= req.wdata & PHASE_MASK;
			if (hit_t1_ph) t1_phase <= req.wdata & PHASE_MASK;
		end
	end

	// Read mux; phase registers show their fixed top bit
	logic [7:0] next_rdata;
	assign next_rdata =
		hit_src ? src_sel :
		hit_e1_lo ? e1_lo :
		hit_e1_hi ? e1_hi :
		hit_t1_lo ? t1_lo :
		hit_t1_hi ? t1_hi :
		hit_in ? in_div :
		hit_fb ? fb_div :
		hit_e1_ph ? (e1_phase | PHASE_FIXED) :
		hit_t1_ph ? (t1_phase | PHASE_FIXED) :
		8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
			reg_hit <= 1'b0;
		end else if (ce) begin
			if (req.rd) reg_rdata <= next_rdata;
			reg_hit <= (req.rd | req.wr) & any_hit;
		end
	end

	// Mode bits
	assign flexible_clock_enable = e1_hi[FLEX_BIT];
	assign rx_decoder_mode_bit = e1_hi[7];
	assign rx_decoder_direction_bit = e1_hi[6];
	assign rx_decoder_select_bit = e1_hi[5];

	// Effective settings: registers in flexible mode, defaults otherwise
	pll_cfg_t reg_cfg;
	pll_cfg_t def_cfg;
	assign reg_cfg = '{
		in_div: in_div[4:0],
		fb_div: fb_div[5:0],
		e1_corr: {e1_hi[3:0], e1_lo},
		t1_corr: {t1_hi[3:0], t1_lo},
		e1_sixths: e1_phase[6:4],
		e1_int: e1_phase[3:0],
		t1_sixths: t1_phase[6:4],
		t1_int: t1_phase[3:0]
	};
	assign def_cfg = '{
		in_div: DEF_IN_DIV,
		fb_div: DEF_FB_DIV,
		e1_corr: DEF_E1_CORR,
		t1_corr: DEF_T1_CORR,
		e1_sixths: DEF_SIXTHS,
		e1_int: DEF_INT,
		t1_sixths: DEF_SIXTHS,
		t1_int: DEF_INT
	};
	pll_cfg_t next_cfg;
	assign next_cfg = flexible_clock_enable ? reg_cfg : def_cfg;

	always_ff @(posedge clk) begin
		if (rst) pll_cfg <= def_cfg;
		else if (ce) pll_cfg <= next_cfg;
	end

	// In flexible mode only, zero dividers or out-of-range divisors are flagged, not corrected
	assign divider_out_of_range = flexible_clock_enable & ((reg_cfg.in_div == 5'h00)
		| (reg_cfg.fb_div == 6'h00) | (reg_cfg.e1_int == 4'h0) | (reg_cfg.t1_int == 4'h0)
		| (reg_cfg.e1_sixths > DEF_SIXTHS) | (reg_cfg.t1_sixths > DEF_SIXTHS));

	// PLL reset on divider writes, async interface and flexible mode only
	wire async_if = (host_interface_mode[1] == 1'b0);
	wire pll_trig = wr_en & (hit_in | hit_fb) & async_if & flexible_clock_enable;

	pll_reset_gen #(
		.WIDTH(PLL_RST_LEN)
	) u_pll_rst (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.trigger(pll_trig),
		.pll_reset(pll_reset)
	);

	// Shared output source selection
	chan_mux #(
		.CHANNELS(CHANNELS)
	) u_fs_mux (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.sel(src_sel[FSS_LSB +: 3]),
		.src(chan_frame_sync),
		.out(frame_sync_output),
		.reserved_sel(frame_sync_sel_reserved)
	);

	chan_mux #(
		.CHANNELS(CHANNELS)
	) u_rc_mux (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.sel(src_sel[R1S_LSB +: 3]),
		.src(chan_recv_clock),
		.out(shared_recv_clock_one),
		.reserved_sel(recv_clock_sel_reserved)
	);
endmodule

/* logic/pll_reset_gen.sv */
// Stretches a PLL reset request into a fixed-length pulse
`timescale 1ns/1ps
module pll_reset_gen
	import clk_cfg_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clocking
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Request and pulse
	input wire logic trigger,
	output logic pll_reset
);
	// The pulse counter is four bits wide
	if (WIDTH < 1 || WIDTH > 15) begin : g_bad_width
		$error("pll_reset_gen WIDTH out of range");
	end
	logic [3:0] count;
	always_ff @(posedge clk) begin
		if (rst) count <= 4'h0;
		else if (ce) begin
			if (trigger) count <= 4'(WIDTH);
			else if (count != 4'h0) count <= count - 4'h1;
		end
	end
	assign pll_reset = (count != 4'h0);
endmodule

/* sim/master_clock_pll_config_monitor.sv */
// Checker of the clock configuration block's port behaviour
`timescale 1ns/1ps
module master_clock_pll_config_monitor
	import clk_cfg_pkg::*;
(
	// Watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_hit,
	input wire logic [1:0] host_interface_mode,
	input wire logic frame_sync_output,
	input wire logic frame_sync_sel_reserved,
	input wire pll_cfg_t pll_cfg,
	input wire logic flexible_clock_enable,
	input wire logic pll_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire rd_go = ce && reg_rd;
	wire w_in = ce && reg_wr && reg_addr == OFF_PLL_IN_DIV;
	property p_hit; rd_go && reg_addr == OFF_SRC_SEL |=> reg_hit; endproperty
	a_hit: assert property (p_hit) else $error("no hit on mapped read");
	property p_miss; rd_go && reg_addr == 8'h8b |=> !reg_hit && reg_rdata == 8'h00; endproperty
	a_miss: assert property (p_miss) else $error("unmapped read answered");
	property p_trig; w_in && !host_interface_mode[1] && flexible_clock_enable |=> pll_reset; endproperty
	a_trig: assert property (p_trig) else $error("divider write gave no pll reset");
	property p_quiet; w_in && host_interface_mode[1] && !pll_reset |=> !pll_reset; endproperty
	a_quiet: assert property (p_quiet) else $error("pll reset on sync interface");
	property p_e1ph; rd_go && reg_addr == OFF_E1_PHASE |=> reg_rdata[7]; endproperty
	a_e1ph: assert property (p_e1ph) else $error("e1 phase bit 7 not one");
	property p_t1ph; rd_go && reg_addr == OFF_T1_PHASE |=> reg_rdata[7]; endproperty
	a_t1ph: assert property (p_t1ph) else $error("t1 phase bit 7 not one");
	property p_res; ce && frame_sync_sel_reserved |=> !frame_sync_output; endproperty
	a_res: assert property (p_res) else $error("reserved code drives frame sync");
	property p_div;
		w_in && flexible_clock_enable ##1 ce && !reg_wr |=> pll_cfg.in_div == $past(reg_wdata[4:0], 2);
	endproperty
	a_div: assert property (p_div) else $error("input divider not applied");
	c_trig: cover property (w_in ##1 pll_reset);
	c_res: cover property (frame_sync_sel_reserved);
	c_ph: cover property (rd_go && reg_addr == OFF_T1_PHASE);
endmodule

bind master_clock_pll_config master_clock_pll_config_monitor master_clock_pll_config_monitor_i (
	.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
	.host_interface_mode(host_interface_mode), .frame_sync_output(frame_sync_output),
	.frame_sync_sel_reserved(frame_sync_sel_reserved), .pll_cfg(pll_cfg),
	.flexible_clock_enable(flexible_clock_enable), .pll_reset(pll_reset));

/* sim/tb_master_clock_pll_config.sv */
// Self-checking bench of the clock configuration block
`timescale 1ns/1ps
module tb_master_clock_pll_config;
	import clk_cfg_pkg::*;
	localparam int RST_LEN = 3;
	logic clk = 0;
	logic rst = 1;
	logic ce = 1;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic rd_seen = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic [1:0] mode = 2'h0;
	logic [3:0] fs_src = 4'h0;
	logic [3:0] rc_src = 4'h0;
	logic [7:0] reg_rdata;
	logic reg_hit, fso, rco, fsr, rcr, flex, pll_reset;
	logic [3:0] n;
	logic [2:0] dec;
	logic oor;
	pll_cfg_t cfg;
	logic [8:0] expq[$];
	logic [31:0] lf = 32'h00011208;
	logic [7:0] adr [9] = '{OFF_SRC_SEL, OFF_E1_CORR_LO, OFF_E1_CORR_HI, OFF_T1_CORR_LO,
		OFF_T1_CORR_HI, OFF_PLL_IN_DIV, OFF_PLL_FB_DIV, OFF_E1_PHASE, OFF_T1_PHASE};
	logic [7:0] msk [9] = '{8'h77, 8'hff, 8'hff, 8'hff, 8'hef, 8'h9f, 8'h3f, 8'h7f, 8'h7f};
	// Recommended set for a 2.048 MHz master clock, in register order from index 1
	logic [7:0] rec [9] = '{8'h00, 8'h00, 8'h18, 8'hfb, 8'h0b, 8'h00, 8'h2f, 8'hdb, 8'hdf};
	logic [7:0] wv [9];
	int num_errors = 0;
	int num_checks = 0;
	always #25 clk = ~clk;
	master_clock_pll_config #(.PLL_RST_LEN(RST_LEN)) master_clock_pll_config_i (
		.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
		.host_interface_mode(mode), .chan_frame_sync(fs_src), .chan_recv_clock(rc_src),
		.frame_sync_output(fso), .shared_recv_clock_one(rco), .frame_sync_sel_reserved(fsr),
		.recv_clock_sel_reserved(rcr), .pll_cfg(cfg), .flexible_clock_enable(flex),
		.rx_decoder_mode_bit(dec[2]), .rx_decoder_direction_bit(dec[1]),
		.rx_decoder_select_bit(dec[0]), .divider_out_of_range(oor), .pll_reset(pll_reset));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [48:0] got, input logic [48:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic idle();
		reg_wr = 0;
		reg_rd = 0;
		@(posedge clk);
		#2;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1;
		reg_rd = 0;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#2;
	endtask
	task automatic rd(input logic [7:0] a, input logic [8:0] e);
		reg_rd = 1;
		reg_wr = 0;
		reg_addr = a;
		expq.push_back(e);
		@(posedge clk);
		#2;
	endtask
	// Read data lands on the same edge that takes the strobe and is checked on the falling edge after it
	always @(posedge clk) rd_seen <= reg_rd;
	always @(negedge clk) if (rd_seen) chk(49'({reg_hit, reg_rdata}), 49'(expq.pop_front()));
	initial begin
		repeat (20) @(posedge clk);
		#2;
		rst = 0;
		for (int i = 0; i < 9; i++)
			rd(adr[i], {1'b1, (i == 2) ? RST_E1_CORR_HI : (i > 6) ? PHASE_FIXED : 8'h00});
		// Flexible mode is on out of reset and the zero dividers are flagged
		chk(49'({dec, flex, oor}), 49'({RST_E1_CORR_HI[7:4], 1'b1}));
		for (int i = 0; i < 9; i++) begin
			wv[i] = (lf[7:0] & msk[i]) | ((i > 6) ? PHASE_FIXED : 8'h00);
			wr(adr[i], lf[7:0]);
			lf = nx(lf);
		end
		wr(8'h8b, 8'hff);
		for (int i = 0; i < 9; i++)
			rd(adr[i], {1'b1, wv[i]});
		rd(8'h8b, 9'h000);
		chk(49'({dec, flex}), 49'(wv[2][7:4]));
		for (int c = 0; c < 8; c++) begin
			wr(OFF_SRC_SEL, {1'b0, 3'(c), 1'b0, 3'(c)});
			fs_src = lf[3:0];
			rc_src = lf[7:4];
			lf = nx(lf);
			idle();
			idle();
			chk(49'({fso, rco, fsr, rcr}), 49'({fs_src[c % 4] & (c < 4), rc_src[c % 4] & (c < 4),
				c > 3, c > 3}));
		end
		// A write while the clock enable is low must be lost
		ce = 0;
		wr(OFF_SRC_SEL, 8'h00);
		ce = 1;
		rd(OFF_SRC_SEL, 9'h177);
		wr(OFF_E1_CORR_LO, lf[7:0]);
		wr(OFF_E1_CORR_HI, {4'h1, lf[11:8]});
		wr(OFF_T1_CORR_LO, lf[19:12]);
		wr(OFF_T1_CORR_HI, {4'he, lf[23:20]});
		wr(OFF_PLL_IN_DIV, 8'h9f);
		wr(OFF_PLL_FB_DIV, 8'h3f);
		wr(OFF_E1_PHASE, 8'h5f);
		wr(OFF_T1_PHASE, 8'h01);
		idle();
		idle();
		chk(49'(cfg), {5'h1f, 6'h3f, lf[11:0], lf[23:12], 3'h5, 4'hf, 3'h0, 4'h1});
		chk(49'(oor), 49'h0);
		wr(OFF_E1_CORR_HI, 8'h00);
		idle();
		idle();
		chk(49'(cfg), {DEF_IN_DIV, DEF_FB_DIV, DEF_E1_CORR, DEF_T1_CORR, DEF_SIXTHS, DEF_INT,
			DEF_SIXTHS, DEF_INT});
		chk(49'(oor), 49'h0);
		for (int k = 0; k < 8; k++) begin
			mode = {k[1], lf[0]};
			lf = nx(lf);
			wr(OFF_E1_CORR_HI, {3'h0, k[0], 4'h0});
			idle();
			wr(k[2] ? OFF_PLL_FB_DIV : OFF_PLL_IN_DIV, 8'h01);
			n = 4'h0;
			repeat (8) begin
				n += pll_reset;
				idle();
			end
			chk(49'(n), (k[0] && !k[1]) ? 49'(RST_LEN) : 49'h0);
		end
		// 2.048 MHz master clock: M=0, N=33 gives a 278.528 MHz PLL
		wr(OFF_PLL_IN_DIV, 8'h00);
		wr(OFF_PLL_FB_DIV, 8'h21);
		wr(OFF_E1_PHASE, 8'h28);
		wr(OFF_T1_PHASE, 8'h2b);
		wr(OFF_E1_CORR_LO, 8'h00);
		wr(OFF_E1_CORR_HI, 8'h18);
		wr(OFF_T1_CORR_LO, 8'hd2);
		wr(OFF_T1_CORR_HI, 8'h02);
		idle();
		idle();
		chk(49'(cfg), {5'h00, 6'h21, 12'h800, 12'h2d2, 3'h2, 4'h8, 3'h2, 4'hb});
		chk(49'({dec, oor}), 49'({3'h0, 1'b1}));
		for (int i = 1; i < 9; i++)
			wr(adr[i], rec[i]);
		idle();
		idle();
		chk(49'(cfg), {5'h00, 6'h2f, 12'h800, 12'hbfb, 3'h5, 4'hb, 3'h5, 4'hf});
		rd(OFF_T1_PHASE, 9'h1df);
		idle();
		test_done();
	end
	// About ten times the length of the sequence above
	initial begin
		#100000;
		num_errors++;
		test_done();
	end
endmodule
